/* File: logic/umpl_pins.sv */
`timescale 1ns/100ps
`include "umpl_cfg.svh"

module umpl_pins
    import umpl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // UART core side
    input wire logic core_tx_bit,
    input wire logic core_tx_busy,
    input wire logic core_ir_tx,
    input wire logic core_rx_ready,
    input wire logic core_rts_flow,
    output logic core_rx_bit,
    output logic core_ir_rx,
    output logic core_tx_allow,
    // Serial pins
    input wire logic chan_a_serial_in,
    output logic chan_a_serial_out,
    output logic chan_a_request_to_send_n,
    input wire logic chan_a_clear_to_send_n,
    output logic chan_a_terminal_ready_n,
    input wire logic chan_a_set_ready_n,
    input wire logic chan_a_carrier_detect_n,
    input wire logic chan_a_ring_indicator_n,
    output logic chan_a_multifunction_out_n
);
    logic [7:0] modem_control_reg_ff;
    logic [7:0] feature_control_reg_ff;
    logic [7:0] enhanced_feature_reg_ff;
    logic [7:0] enhanced_mode_select_reg_ff;
    logic [7:0] interrupt_enable_reg_ff;
    logic [7:0] alternate_function_reg_ff;
    logic [15:0] baud_div_ff;
    logic [15:0] baud_cnt_ff;
    logic baud_clk_ff;
    logic [4:0] sync1_ff, sync2_ff, sync3_ff, pin_ff;
    logic tx_out_ff, rts_n_ff, dtr_n_ff, mf_n_ff;
    logic [31:0] prdata_ff;
    logic wr_en, rd_en, hit;
    logic ir_mode, auto_rts, auto_cts, rs485;
    umpl_mf_sel_e mf_sel;

    function automatic logic [7:0] byte_wr(input logic [7:0] old);
        byte_wr = pstrb[0] ? pwdata[7:0] : old;
    endfunction

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_ff;
    assign ir_mode = modem_control_reg_ff[`UMPL_MCR_IR];
    assign auto_rts = enhanced_feature_reg_ff[`UMPL_EFR_AUTORTS];
    assign auto_cts = enhanced_feature_reg_ff[`UMPL_EFR_AUTOCTS];
    assign rs485 = feature_control_reg_ff[`UMPL_FEATURE_CONTROL_REG_RS485];
    assign mf_sel = umpl_mf_sel_e'(
        alternate_function_reg_ff[`UMPL_AFR_SEL_HI:`UMPL_AFR_SEL_LO]);

    always_comb begin
        unique case (paddr)
            `UMPL_ADDR_MODEM_CTRL, `UMPL_ADDR_FEATURE,
            `UMPL_ADDR_ENH_FEATURE, `UMPL_ADDR_ENH_MODE,
            `UMPL_ADDR_INT_ENABLE, `UMPL_ADDR_ALT_FUNC,
            `UMPL_ADDR_PIN_STATUS, `UMPL_ADDR_BAUD_DIV: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~hit;

    // Register writes
    always_ff @(posedge clock) begin
        if (srst) begin
            modem_control_reg_ff <= `UMPL_RST_BYTE;
            feature_control_reg_ff <= `UMPL_RST_BYTE;
            enhanced_feature_reg_ff <= `UMPL_RST_BYTE;
            enhanced_mode_select_reg_ff <= `UMPL_RST_BYTE;
            interrupt_enable_reg_ff <= `UMPL_RST_BYTE;
            alternate_function_reg_ff <= `UMPL_RST_BYTE;
            baud_div_ff <= `UMPL_RST_DIV;
        end else if (wr_en) begin
            unique case (paddr)
                `UMPL_ADDR_MODEM_CTRL:
                    modem_control_reg_ff <= byte_wr(modem_control_reg_ff);
                `UMPL_ADDR_FEATURE:
                    feature_control_reg_ff <= byte_wr(feature_control_reg_ff);
                `UMPL_ADDR_ENH_FEATURE:
                    enhanced_feature_reg_ff <=
                        byte_wr(enhanced_feature_reg_ff);
                `UMPL_ADDR_ENH_MODE:
                    enhanced_mode_select_reg_ff <=
                        byte_wr(enhanced_mode_select_reg_ff);
                `UMPL_ADDR_INT_ENABLE:
                    interrupt_enable_reg_ff <=
                        byte_wr(interrupt_enable_reg_ff);
                `UMPL_ADDR_ALT_FUNC:
                    alternate_function_reg_ff <=
                        byte_wr(alternate_function_reg_ff);
                `UMPL_ADDR_BAUD_DIV: begin
                    if (pstrb[0]) begin
                        baud_div_ff[7:0] <= pwdata[7:0];
                    end
                    if (pstrb[1]) begin
                        baud_div_ff[15:8] <= pwdata[15:8];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Read data captured in setup phase
    always_ff @(posedge clock) begin
        if (srst) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (paddr)
                `UMPL_ADDR_MODEM_CTRL:
                    prdata_ff <= {24'h000000, modem_control_reg_ff};
                `UMPL_ADDR_FEATURE:
                    prdata_ff <= {24'h000000, feature_control_reg_ff};
                `UMPL_ADDR_ENH_FEATURE:
                    prdata_ff <= {24'h000000, enhanced_feature_reg_ff};
                `UMPL_ADDR_ENH_MODE:
                    prdata_ff <= {24'h000000, enhanced_mode_select_reg_ff};
                `UMPL_ADDR_INT_ENABLE:
                    prdata_ff <= {24'h000000, interrupt_enable_reg_ff};
                `UMPL_ADDR_ALT_FUNC:
                    prdata_ff <= {24'h000000, alternate_function_reg_ff};
                `UMPL_ADDR_PIN_STATUS:
                    prdata_ff <= {27'h0000000, pin_ff};
                `UMPL_ADDR_BAUD_DIV:
                    prdata_ff <= {16'h0000, baud_div_ff};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Three-stage pin synchronisers, change taken when stages 2 and 3 agree
    always_ff @(posedge clock) begin
        if (srst) begin
            sync1_ff <= 5'h1f;
            sync2_ff <= 5'h1f;
            sync3_ff <= 5'h1f;
            pin_ff <= 5'h1f;
        end else begin
            sync1_ff <= {chan_a_ring_indicator_n, chan_a_carrier_detect_n,
                chan_a_set_ready_n, chan_a_clear_to_send_n,
                chan_a_serial_in};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            for (int i = 0; i < 5; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    pin_ff[i] <= sync3_ff[i];
                end
            end
        end
    end

    sequence rx_stages_agree;
        sync2_ff[0] == sync3_ff[0] && sync3_ff[0] != pin_ff[0];
    endsequence

    AST_SYNC: assert property (
        @(posedge clock) disable iff (srst)
        $changed(pin_ff[0]) |-> $past(sync2_ff[0]) == $past(sync3_ff[0]))
        else $error("Input changed without agreement");
    AST_SYNC_TAKE: assert property (
        @(posedge clock) disable iff (srst)
        rx_stages_agree |=> pin_ff[0] == $past(sync3_ff[0]))
        else $error("Agreed input not taken");

    // Receive path, standard and infrared with optional inversion
    assign core_rx_bit = pin_ff[0];
    assign core_ir_rx = ir_mode &
        (pin_ff[0] ^ feature_control_reg_ff[`UMPL_FEATURE_CONTROL_REG_IRINV]);
    assign core_tx_allow = ~auto_cts | ~pin_ff[1];

    AST_IR_INV: assert property (
        @(posedge clock) disable iff (srst)
        core_ir_rx == (ir_mode &&
        (core_rx_bit != feature_control_reg_ff[`UMPL_FEATURE_CONTROL_REG_IRINV])))
        else $error("Infrared receive inversion wrong");
    AST_CTS_GATE: assert property (
        @(posedge clock) disable iff (srst)
        auto_cts && pin_ff[1] |-> !core_tx_allow)
        else $error("Clear-to-send did not gate transmit");
    AST_STATUS_INERT: assert property (
        @(posedge clock) disable iff (srst)
        $changed(pin_ff[4:2]) && $stable(pin_ff[1]) && $stable(auto_cts)
        |-> $stable(core_tx_allow))
        else $error("Status input altered transmit gating");

    // Transmit pin
    always_ff @(posedge clock) begin
        if (srst) begin
            tx_out_ff <= 1'b1;
        end else if (ir_mode) begin
            tx_out_ff <= core_tx_busy & core_ir_tx;
        end else begin
            tx_out_ff <= ~core_tx_busy | core_tx_bit;
        end
    end
    assign chan_a_serial_out = tx_out_ff;

    AST_TX_IDLE_STD: assert property (
        @(posedge clock) disable iff (srst)
        !ir_mode && !core_tx_busy && !$past(ir_mode) |=> tx_out_ff)
        else $error("Standard idle transmit not high");
    AST_TX_IDLE_IR: assert property (
        @(posedge clock) disable iff (srst)
        ir_mode && !core_tx_busy |=> !tx_out_ff)
        else $error("Infrared idle transmit not low");
    AST_RESET_IDLE: assert property (
        @(posedge clock)
        srst |=> chan_a_serial_out && chan_a_request_to_send_n &&
        chan_a_terminal_ready_n && chan_a_multifunction_out_n)
        else $error("Outputs not idle after reset");

    // Modem outputs
    always_ff @(posedge clock) begin
        if (srst) begin
            rts_n_ff <= 1'b1;
            dtr_n_ff <= 1'b1;
        end else begin
            if (rs485) begin
                rts_n_ff <= ~core_tx_busy;
            end else if (auto_rts) begin
                rts_n_ff <= ~(modem_control_reg_ff[`UMPL_MCR_RTS] &
                    core_rts_flow);
            end else begin
                rts_n_ff <= ~modem_control_reg_ff[`UMPL_MCR_RTS];
            end
            dtr_n_ff <= ~modem_control_reg_ff[`UMPL_MCR_DTR];
        end
    end
    assign chan_a_request_to_send_n = rts_n_ff;
    assign chan_a_terminal_ready_n = dtr_n_ff;

    AST_RS485: assert property (
        @(posedge clock) disable iff (srst)
        rs485 && core_tx_busy |=> !chan_a_request_to_send_n)
        else $error("Direction control not asserted");
    AST_AUTO_RTS: assert property (
        @(posedge clock) disable iff (srst)
        !rs485 && auto_rts && !core_rts_flow |=> chan_a_request_to_send_n)
        else $error("Request-to-send not released by flow control");
    AST_DTR: assert property (
        @(posedge clock) disable iff (srst)
        $rose(modem_control_reg_ff[`UMPL_MCR_DTR]) |=>
        !chan_a_terminal_ready_n)
        else $error("Terminal ready not driven low");

    // Sixteen-times baud clock
    always_ff @(posedge clock) begin
        if (srst) begin
            baud_cnt_ff <= 16'h0000;
            baud_clk_ff <= 1'b0;
        end else if (baud_cnt_ff >= baud_div_ff - 16'h0001) begin
            baud_cnt_ff <= 16'h0000;
            baud_clk_ff <= ~baud_clk_ff;
        end else begin
            baud_cnt_ff <= baud_cnt_ff + 16'h0001;
        end
    end

    // Multi-function output
    always_ff @(posedge clock) begin
        if (srst) begin
            mf_n_ff <= 1'b1;
        end else begin
            unique case (mf_sel)
                UMPL_MF_GPO:
                    mf_n_ff <= ~modem_control_reg_ff[`UMPL_MCR_OP2];
                UMPL_MF_BAUD: mf_n_ff <= baud_clk_ff;
                UMPL_MF_RXRDY: mf_n_ff <= ~core_rx_ready;
                default: mf_n_ff <= 1'b1;
            endcase
        end
    end
    assign chan_a_multifunction_out_n = mf_n_ff;

    AST_OP2: assert property (
        @(posedge clock) disable iff (srst)
        mf_sel == UMPL_MF_GPO && modem_control_reg_ff[`UMPL_MCR_OP2]
        && $stable(mf_sel) |=> !chan_a_multifunction_out_n)
        else $error("General output not low");
    AST_RXRDY: assert property (
        @(posedge clock) disable iff (srst)
        mf_sel == UMPL_MF_RXRDY && core_rx_ready |=>
        !chan_a_multifunction_out_n)
        else $error("Receive ready not low");
    AST_MF_RSVD: assert property (
        @(posedge clock) disable iff (srst)
        mf_sel == UMPL_MF_RSVD |=> chan_a_multifunction_out_n)
        else $error("Unused selection not held high");
endmodule

/* File: logic/umpl_cfg.svh */
`ifndef UMPL_CFG_SVH
`define UMPL_CFG_SVH

// Register byte offsets
`define UMPL_ADDR_MODEM_CTRL 12'h000
`define UMPL_ADDR_FEATURE 12'h004
`define UMPL_ADDR_ENH_FEATURE 12'h008
`define UMPL_ADDR_ENH_MODE 12'h00c
`define UMPL_ADDR_INT_ENABLE 12'h010
`define UMPL_ADDR_ALT_FUNC 12'h014
`define UMPL_ADDR_PIN_STATUS 12'h018
`define UMPL_ADDR_BAUD_DIV 12'h01c

// Field positions
`define UMPL_MCR_DTR 0
`define UMPL_MCR_RTS 1
`define UMPL_MCR_OP2 3
`define UMPL_MCR_IR 6
`define UMPL_FEATURE_CONTROL_REG_IRINV 2
`define UMPL_FEATURE_CONTROL_REG_RS485 3
`define UMPL_EFR_AUTORTS 6
`define UMPL_EFR_AUTOCTS 7
`define UMPL_AFR_SEL_LO 1
`define UMPL_AFR_SEL_HI 2

// Reset values
`define UMPL_RST_BYTE 8'h00
`define UMPL_RST_DIV 16'h0001

`endif

/* File: logic/umpl_pkg.sv */
package umpl_pkg;
    typedef enum logic [1:0] {
        UMPL_MF_GPO,
        UMPL_MF_BAUD,
        UMPL_MF_RXRDY,
        UMPL_MF_RSVD
    } umpl_mf_sel_e;
endpackage

/* File: test/umpl_far_end.sv */
`timescale 1ns/100ps

// Line transceiver and modem seen from the serial pins
module umpl_far_end (
    // Bench control
    input wire logic ir_idle,
    input wire logic send_valid,
    input wire logic send_bit,
    input wire logic cts_hold,
    input wire logic [2:0] status_n,
    // Pins toward the block
    output logic serial_in,
    output logic clear_to_send_n,
    output logic set_ready_n,
    output logic carrier_detect_n,
    output logic ring_indicator_n
);
    // Idle level: high on a standard line, low on infrared
    assign serial_in = send_valid ? send_bit : !ir_idle;
    assign clear_to_send_n = cts_hold;
    assign {ring_indicator_n, carrier_detect_n, set_ready_n} = status_n;
endmodule

/* File: test/tb_top.sv */
`timescale 1ns/100ps
`include "umpl_cfg.svh"

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    fails++; $display("BAD %0t got %h exp %h", $time, got, exp); end end

module tb_top;
    import umpl_pkg::*;
    logic clock, srst, psel, penable, pwrite, pready, pslverr, err, prev;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic tx_bit, tx_busy, ir_tx, rx_ready, rts_flow, rx_bit, ir_rx;
    logic tx_allow, ir_idle, send_valid, send_bit, cts_hold;
    logic [2:0] status_n;
    logic s_in, s_out, rts_n, cts_n, dtr_n, dsr_n, cd_n, ri_n, mf_n;
    int fails, n_compared, toggles;

    umpl_pins umpl_pins_inst (.clock(clock), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_tx_bit(tx_bit), .core_tx_busy(tx_busy), .core_ir_tx(ir_tx),
        .core_rx_ready(rx_ready), .core_rts_flow(rts_flow),
        .core_rx_bit(rx_bit), .core_ir_rx(ir_rx), .core_tx_allow(tx_allow),
        .chan_a_serial_in(s_in), .chan_a_serial_out(s_out),
        .chan_a_request_to_send_n(rts_n), .chan_a_clear_to_send_n(cts_n),
        .chan_a_terminal_ready_n(dtr_n), .chan_a_set_ready_n(dsr_n),
        .chan_a_carrier_detect_n(cd_n), .chan_a_ring_indicator_n(ri_n),
        .chan_a_multifunction_out_n(mf_n));

    umpl_far_end umpl_far_end_inst (.ir_idle(ir_idle),
        .send_valid(send_valid), .send_bit(send_bit), .cts_hold(cts_hold),
        .status_n(status_n), .serial_in(s_in), .clear_to_send_n(cts_n),
        .set_ready_n(dsr_n), .carrier_detect_n(cd_n),
        .ring_indicator_n(ri_n));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic finish_test();
        if (fails == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        finish_test();
    end

    initial begin
        {srst, pstrb} = {1'b1, 4'hf};
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {tx_bit, tx_busy, ir_tx, rx_ready, rts_flow} = 5'b00001;
        {ir_idle, send_valid, send_bit, cts_hold, status_n} = 7'b0001111;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        wt(1);
        `CHK(s_out, 1'b1)
        `CHK({rts_n, dtr_n, mf_n}, 3'b111)
        apb(1'b0, `UMPL_ADDR_MODEM_CTRL, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 12'h020, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        apb(1'b1, `UMPL_ADDR_MODEM_CTRL, 32'h0b);
        wt(2);
        `CHK({rts_n, dtr_n, mf_n}, 3'b000)
        tx_busy <= 1'b1;
        wt(2);
        `CHK(s_out, 1'b0)
        tx_busy <= 1'b0;
        wt(2);
        `CHK(s_out, 1'b1)
        ir_idle <= 1'b1;
        apb(1'b1, `UMPL_ADDR_MODEM_CTRL, 32'h4b);
        wt(2);
        `CHK(s_out, 1'b0)
        tx_busy <= 1'b1;
        ir_tx <= 1'b1;
        wt(6);
        `CHK({s_out, ir_rx}, 2'b10)
        tx_busy <= 1'b0;
        apb(1'b1, `UMPL_ADDR_FEATURE, 32'h04);
        wt(2);
        `CHK(ir_rx, 1'b1)
        send_valid <= 1'b1;
        send_bit <= 1'b1;
        wt(6);
        `CHK({ir_rx, rx_bit}, 2'b01)
        send_valid <= 1'b0;
        ir_idle <= 1'b0;
        apb(1'b1, `UMPL_ADDR_MODEM_CTRL, 32'h0b);
        apb(1'b1, `UMPL_ADDR_FEATURE, 32'h0);
        wt(6);
        `CHK({ir_rx, rx_bit}, 2'b01)
        // Request-to-send was asserted above, before auto flow goes on
        apb(1'b1, `UMPL_ADDR_ENH_FEATURE, 32'hc0);
        wt(6);
        `CHK(tx_allow, 1'b0)
        rts_flow <= 1'b0;
        wt(2);
        `CHK(rts_n, 1'b1)
        rts_flow <= 1'b1;
        wt(2);
        `CHK(rts_n, 1'b0)
        status_n <= 3'b000;
        wt(6);
        `CHK(tx_allow, 1'b0)
        apb(1'b0, `UMPL_ADDR_PIN_STATUS, 32'h0);
        `CHK(rd[4:0], 5'b00011)
        cts_hold <= 1'b0;
        wt(6);
        `CHK(tx_allow, 1'b1)
        apb(1'b1, `UMPL_ADDR_FEATURE, 32'h08);
        tx_busy <= 1'b1;
        wt(2);
        `CHK(rts_n, 1'b0)
        tx_busy <= 1'b0;
        wt(2);
        `CHK(rts_n, 1'b1)
        apb(1'b1, `UMPL_ADDR_ALT_FUNC, 32'h04);
        rx_ready <= 1'b1;
        wt(2);
        `CHK(mf_n, 1'b0)
        rx_ready <= 1'b0;
        wt(2);
        `CHK(mf_n, 1'b1)
        apb(1'b1, `UMPL_ADDR_ALT_FUNC, 32'h0);
        wt(2);
        `CHK(mf_n, 1'b0)
        apb(1'b1, `UMPL_ADDR_ALT_FUNC, 32'h06);
        wt(2);
        `CHK(mf_n, 1'b1)
        apb(1'b1, `UMPL_ADDR_BAUD_DIV, 32'h2);
        apb(1'b1, `UMPL_ADDR_ALT_FUNC, 32'h02);
        wt(4);
        toggles = 0;
        prev = mf_n;
        repeat (16) begin
            wt(1);
            toggles += int'(mf_n !== prev);
            prev = mf_n;
        end
        `CHK(toggles, 8)
        srst <= 1'b1;
        wt(2);
        srst <= 1'b0;
        apb(1'b0, `UMPL_ADDR_MODEM_CTRL, 32'h0);
        `CHK(rd, 32'h0)
        `CHK({s_out, rts_n, dtr_n, mf_n}, 4'b1111)
        finish_test();
    end
endmodule
